// >>> shared/sli_pkg.sv
// ==========================================================
// status light constants
package sli_pkg;

  // ==========================================================
  // clock and timing, all light times counted in milliseconds
  localparam int unsigned CLK_HZ      = 200_000_000;      // system clock
  localparam int unsigned MS_PER_S    = 1000;             // ms in one second
  localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S; // cycles per ms
  localparam logic [11:0] BLINK_HALF_MS   = 12'h1F4;      // 500 ms, 1 Hz blink
  localparam logic [11:0] PWR_PERIOD_MS   = 12'h3E8;      // 1000 ms power cycle
  localparam logic [11:0] PWR_PULSE_MS    = 12'h064;      // 100 ms green pulse
  localparam logic [11:0] ERR_ON_MS       = 12'h0C8;      // 200 ms red flash
  localparam logic [11:0] ERR_OFF_MS      = 12'h0C8;      // 200 ms gap
  localparam logic [11:0] ERR_PAUSE_MS    = 12'h7D0;      // 2000 ms burst pause
  localparam logic [11:0] STARTUP_STEP_MS = 12'h0FA;      // 250 ms per step
  localparam logic [1:0]  STARTUP_LAST    = 2'h3;         // four start steps

  // ==========================================================
  // error numbers shown on the power light
  localparam logic [2:0] ERR_NONE        = 3'h0;
  localparam logic [2:0] ERR_GENERAL     = 3'h1;
  localparam logic [2:0] ERR_VOLTAGE     = 3'h2;
  localparam logic [2:0] ERR_TEMPERATURE = 3'h3;
  localparam logic [2:0] ERR_OVERCURRENT = 3'h4;
  localparam logic [2:0] ERR_CONTROLLER  = 3'h5;
  localparam logic [2:0] ERR_WATCHDOG    = 3'h6;

  // ==========================================================
  // register map and fields
  localparam int unsigned ADDR_W       = 8;      // decoded address bits
  localparam logic [7:0]  REG_CTRL     = 8'h00;  // software error number
  localparam logic [7:0]  REG_STATUS   = 8'h04;  // light and state view
  localparam logic [2:0]  CTRL_RST     = 3'h0;   // no software error
  localparam int unsigned ST_TMO_BIT   = 3;      // timeout flag
  localparam int unsigned ST_START_BIT = 4;      // start-up finished
  localparam int unsigned ST_CONN_BIT  = 5;      // first connection seen
  localparam int unsigned ST_LIGHT_LSB = 8;      // six light outputs
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;   // 32-bit transfer
  localparam logic        HRESP_OKAY   = 1'b0;   // only answer given

  // ==========================================================
  // power light burst states, gray on each step except pause to on
  typedef enum logic [1:0] {
    BRS_NORMAL = 2'h0,
    BRS_ON     = 2'h1,
    BRS_OFF    = 2'h3,
    BRS_PAUSE  = 2'h2
  } sli_burst_t;

  // watchdog wins, then hardware number, then software number
  function automatic logic [2:0] sli_err_pick(input logic       wdog,
                                              input logic [2:0] hw,
                                              input logic [2:0] sw);
    logic [2:0] pick;
    pick = (hw != ERR_NONE) ? hw : sw;
    if (wdog) begin
      pick = ERR_WATCHDOG;
    end else if (pick == 3'h7) begin
      pick = ERR_GENERAL;
    end
    return pick;
  endfunction

endpackage

// >>> src/sli_ms_tick.sv
`timescale 1ns/100ps
// ==========================================================
// millisecond tick and 1 Hz blink phase
module sli_ms_tick #(
  parameter int unsigned TICK_CYC = sli_pkg::MS_TICK_CYC
) (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      ms_tick,
  output logic      blink_phase
);
  import sli_pkg::*;

  typedef struct packed {
    logic [31:0] cyc;   // cycles within the ms
    logic [11:0] ms;    // ms within half period
    logic        tick;  // one-cycle ms pulse
    logic        phase; // blink on half
  } sli_tick_st_t;

  sli_tick_st_t tick_ff;
  sli_tick_st_t nxt_tick;

  always_comb begin
    nxt_tick      = tick_ff;
    nxt_tick.tick = 1'b0;
    if (tick_ff.cyc == TICK_CYC - 1) begin
      nxt_tick.cyc  = 32'h0;
      nxt_tick.tick = 1'b1;
      if (tick_ff.ms == BLINK_HALF_MS - 12'h1) begin
        nxt_tick.ms    = 12'h0;
        nxt_tick.phase = ~tick_ff.phase;
      end else begin
        nxt_tick.ms = 12'(tick_ff.ms + 12'h1);
      end
    end else begin
      nxt_tick.cyc = 32'(tick_ff.cyc + 32'h1);
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign ms_tick     = tick_ff.tick;
  assign blink_phase = tick_ff.phase;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_tick_single: assert property (tick_ff.tick |=> !tick_ff.tick)
    else $error("ms tick longer than one cycle");
  a_phase_on_tick: assert property ($changed(tick_ff.phase) |-> tick_ff.tick)
    else $error("blink phase moved without a tick");
endmodule

// >>> src/sli_pwr_burst.sv
`timescale 1ns/100ps
// ==========================================================
// power light: green pulse or red error bursts
module sli_pwr_burst (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       ms_tick,
  input  wire logic [2:0] err_code,
  output logic            pwr_green,
  output logic            pwr_red
);
  import sli_pkg::*;

  typedef struct packed {
    sli_burst_t  fsm;   // burst sequencer
    logic [11:0] ms;    // ms within current phase
    logic [2:0]  left;  // flashes still to give
    logic [2:0]  code;  // number of this burst
    logic        green; // power light green
    logic        red;   // power light red
  } sli_pwr_st_t;

  sli_pwr_st_t pwr_ff;
  sli_pwr_st_t nxt_pwr;

  // sequencer and light decode
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff.fsm)
      BRS_NORMAL: begin
        if (err_code != ERR_NONE) begin
          nxt_pwr.fsm  = BRS_ON;
          nxt_pwr.ms   = 12'h0;
          nxt_pwr.left = err_code;
          nxt_pwr.code = err_code;
        end else if (ms_tick) begin
          nxt_pwr.ms = (pwr_ff.ms == PWR_PERIOD_MS - 12'h1) ? 12'h0
                                                            : 12'(pwr_ff.ms + 12'h1);
        end
      end
      BRS_ON: begin
        if (ms_tick && pwr_ff.ms == ERR_ON_MS - 12'h1) begin
          nxt_pwr.fsm  = BRS_OFF;
          nxt_pwr.ms   = 12'h0;
          nxt_pwr.left = 3'(pwr_ff.left - 3'h1);
        end else if (ms_tick) begin
          nxt_pwr.ms = 12'(pwr_ff.ms + 12'h1);
        end
      end
      BRS_OFF: begin
        if (ms_tick && pwr_ff.ms == ERR_OFF_MS - 12'h1) begin
          nxt_pwr.ms  = 12'h0;
          nxt_pwr.fsm = (pwr_ff.left == 3'h0) ? BRS_PAUSE : BRS_ON;
        end else if (ms_tick) begin
          nxt_pwr.ms = 12'(pwr_ff.ms + 12'h1);
        end
      end
      BRS_PAUSE: begin
        if (ms_tick && pwr_ff.ms == ERR_PAUSE_MS - 12'h1) begin
          nxt_pwr.ms   = 12'h0;
          nxt_pwr.left = err_code;
          nxt_pwr.code = err_code;
          nxt_pwr.fsm  = (err_code != ERR_NONE) ? BRS_ON : BRS_NORMAL;
        end else if (ms_tick) begin
          nxt_pwr.ms = 12'(pwr_ff.ms + 12'h1);
        end
      end
      default: begin
        nxt_pwr.fsm = BRS_NORMAL;
        nxt_pwr.ms  = 12'h0;
      end
    endcase
    nxt_pwr.green = (nxt_pwr.fsm == BRS_NORMAL) && (nxt_pwr.ms < PWR_PULSE_MS);
    nxt_pwr.red   = (nxt_pwr.fsm == BRS_ON);
  end

  // state register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pwr_ff <= '{fsm: BRS_NORMAL, default: '0};
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  assign pwr_green = pwr_ff.green;
  assign pwr_red   = pwr_ff.red;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_enter_pause;
    (pwr_ff.fsm == BRS_OFF) ##1 (pwr_ff.fsm == BRS_PAUSE);
  endsequence
  sequence s_enter_burst;
    (pwr_ff.fsm inside {BRS_NORMAL, BRS_PAUSE}) ##1 (pwr_ff.fsm == BRS_ON);
  endsequence

  a_burst_count: assert property (s_enter_pause |-> pwr_ff.left == 3'h0)
    else $error("burst ended with flashes left");
  a_burst_load: assert property (s_enter_burst |-> pwr_ff.left == pwr_ff.code && pwr_ff.code != 3'h0 && pwr_ff.red)
    else $error("burst started with wrong count");
  a_pause_dark: assert property (pwr_ff.fsm == BRS_PAUSE |-> !pwr_ff.red && !pwr_ff.green)
    else $error("power light lit during pause");
  a_green_idle: assert property (pwr_ff.green |-> pwr_ff.fsm == BRS_NORMAL && !pwr_ff.red)
    else $error("green shown outside normal state");
endmodule

// >>> src/sli_status_led.sv
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
module sli_status_led #(
  parameter int unsigned TICK_CYC = sli_pkg::MS_TICK_CYC
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [2:0]  err_code,
  input  wire logic        wdog_fault,
  input  wire logic        configured,
  input  wire logic        ip_valid,
  input  wire logic        conn_open,
  input  wire logic        eo_timeout,
  input  wire logic        eo_all_up,
  output logic             power_indicator_light_green,
  output logic             power_indicator_light_red,
  output logic             mod_green,
  output logic             mod_red,
  output logic             net_green,
  output logic             net_red
);
  import sli_pkg::*;

  // ==========================================================
  // state of the whole block
  typedef struct packed {
    logic                ready;     // bus ready out
    logic                resp;      // bus response
    logic [31:0]         rdata;     // read data
    logic                wr_pend;   // write data phase due
    logic [ADDR_W-1:0]   waddr;     // write address held
    logic [2:0]          sw_err;    // software error number
    logic [2:0]          code;      // active error number
    logic                tmo;       // exclusive timeout flag
    logic                conn_seen; // first connection made
    logic                started;   // start-up pattern done
    logic [1:0]          step;      // start-up step
    logic [11:0]         st_ms;     // ms within step
    logic                pwr_g;     // power light green
    logic                pwr_r;     // power light red
    logic                mod_g;     // module light green
    logic                mod_r;     // module light red
    logic                net_g;     // network light green
    logic                net_r;     // network light red
  } sli_top_st_t;

  sli_top_st_t top_ff;   // registered state
  sli_top_st_t nxt_top;  // next state

  logic        ms_tick;     // one-cycle ms pulse
  logic        blink_phase; // 1 Hz on half
  logic        burst_g;     // power green from sequencer
  logic        burst_r;     // power red from sequencer
  logic        run;         // state patterns active
  logic [31:0] status_word; // status read view

  // ==========================================================
  // timebase and power light sequencer
  sli_ms_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clock       (clock),
    .reset_n     (reset_n),
    .ms_tick     (ms_tick),
    .blink_phase (blink_phase)
  );

  sli_pwr_burst u_burst (
    .clock     (clock),
    .reset_n   (reset_n),
    .ms_tick   (ms_tick),
    .err_code  (top_ff.code),
    .pwr_green (burst_g),
    .pwr_red   (burst_r)
  );

  // patterns follow state once start-up and first link are over
  assign run = top_ff.started && top_ff.conn_seen;

  // status register layout
  always_comb begin
    status_word                  = 32'h0;
    status_word[2:0]             = top_ff.code;
    status_word[ST_TMO_BIT]      = top_ff.tmo;
    status_word[ST_START_BIT]    = top_ff.started;
    status_word[ST_CONN_BIT]     = top_ff.conn_seen;
    status_word[ST_LIGHT_LSB+:6] = {top_ff.net_r, top_ff.net_g, top_ff.mod_r,
                                    top_ff.mod_g, top_ff.pwr_r, top_ff.pwr_g};
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_top         = top_ff;
    // zero wait states, always okay
    nxt_top.ready   = 1'b1;
    nxt_top.resp    = HRESP_OKAY;
    nxt_top.wr_pend = 1'b0;

    // write data phase lands here
    if (top_ff.wr_pend && top_ff.waddr == REG_CTRL) begin
      nxt_top.sw_err = hwdata[2:0];
    end

    // address phase: decode and prepare read data
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        // only whole-word writes are stored
        nxt_top.wr_pend = (hsize == HSIZE_WORD);
        nxt_top.waddr   = haddr[ADDR_W-1:0];
      end else begin
        case (haddr[ADDR_W-1:0])
          REG_CTRL: begin
            nxt_top.rdata = {29'h0, top_ff.sw_err};
          end
          REG_STATUS: begin
            nxt_top.rdata = status_word;
          end
          default: begin
            // unmapped reads give zero
            nxt_top.rdata = 32'h0;
          end
        endcase
      end
    end

    nxt_top.code = sli_err_pick(wdog_fault, err_code, top_ff.sw_err);

    if (eo_timeout) begin
      nxt_top.tmo = 1'b1;
    end else if (eo_all_up) begin
      nxt_top.tmo = 1'b0;
    end

    // start-up step timer
    if (!top_ff.started && ms_tick) begin
      if (top_ff.st_ms == STARTUP_STEP_MS - 12'h1) begin
        nxt_top.st_ms = 12'h0;
        if (top_ff.step == STARTUP_LAST) begin
          nxt_top.started = 1'b1;
        end else begin
          nxt_top.step = 2'(top_ff.step + 2'h1);
        end
      end else begin
        nxt_top.st_ms = 12'(top_ff.st_ms + 12'h1);
      end
    end

    // first connection ends the waiting blink
    if (top_ff.started && conn_open) begin
      nxt_top.conn_seen = 1'b1;
    end

    // power light registered from sequencer
    nxt_top.pwr_g = burst_g;
    nxt_top.pwr_r = burst_r;

    // module and network lights default dark
    nxt_top.mod_g = 1'b0;
    nxt_top.mod_r = 1'b0;
    nxt_top.net_g = 1'b0;
    nxt_top.net_r = 1'b0;

    if (!top_ff.started) begin
      // start-up walk: each colour of the module and network lights
      case (top_ff.step)
        2'h0: begin
          nxt_top.mod_g = 1'b1;
        end
        2'h1: begin
          nxt_top.mod_r = 1'b1;
        end
        2'h2: begin
          nxt_top.net_g = 1'b1;
        end
        default: begin
          nxt_top.net_r = 1'b1;
        end
      endcase
    end else if (!top_ff.conn_seen) begin
      nxt_top.mod_g = blink_phase;
      nxt_top.net_g = blink_phase;
    end else begin
      // module light
      if (wdog_fault) begin
        nxt_top.mod_r = 1'b1;
      end else if (top_ff.code != ERR_NONE) begin
        nxt_top.mod_r = blink_phase;
      end else if (!configured) begin
        nxt_top.mod_g = blink_phase;
      end else begin
        nxt_top.mod_g = 1'b1;
      end
      // network light
      if (!ip_valid) begin
        nxt_top.net_g = 1'b0;
      end else if (top_ff.tmo) begin
        nxt_top.net_r = blink_phase;
      end else if (conn_open) begin
        nxt_top.net_g = 1'b1;
      end else begin
        nxt_top.net_g = blink_phase;
      end
    end
  end

  // ==========================================================
  // state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      top_ff <= '{ready: 1'b1, sw_err: CTRL_RST, default: '0};
    end else begin
      top_ff <= nxt_top;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign hreadyout                   = top_ff.ready;
  assign hresp                       = top_ff.resp;
  assign hrdata                      = top_ff.rdata;
  assign power_indicator_light_green = top_ff.pwr_g;
  assign power_indicator_light_red   = top_ff.pwr_r;
  assign mod_green                   = top_ff.mod_g;
  assign mod_red                     = top_ff.mod_r;
  assign net_green                   = top_ff.net_g;
  assign net_red                     = top_ff.net_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_run_stable;
    run ##1 run;
  endsequence

  a_bus_okay: assert property (top_ff.ready && top_ff.resp == HRESP_OKAY)
    else $error("bus answer not ready and okay");
  a_wdog_code: assert property (wdog_fault |=> top_ff.code == ERR_WATCHDOG)
    else $error("watchdog not shown as number six");
  a_wait_blink: assert property (top_ff.started && !top_ff.conn_seen |=> top_ff.mod_g == $past(blink_phase) && !top_ff.mod_r && !top_ff.net_r)
    else $error("waiting pattern wrong");
  a_mod_ready: assert property (run && !wdog_fault && top_ff.code == ERR_NONE && configured |=> top_ff.mod_g && !top_ff.mod_r)
    else $error("module light not steady green");
  a_mod_standby: assert property (run && !wdog_fault && top_ff.code == ERR_NONE && !configured |=> top_ff.mod_g == $past(blink_phase) && !top_ff.mod_r)
    else $error("standby blink wrong");
  a_minor_blink: assert property (run && !wdog_fault && top_ff.code != ERR_NONE |=> top_ff.mod_r == $past(blink_phase) && !top_ff.mod_g)
    else $error("minor fault blink wrong");
  a_major_red: assert property (s_run_stable ##0 wdog_fault |=> top_ff.mod_r && !top_ff.mod_g)
    else $error("watchdog not steady red");
  a_net_dark: assert property (run && !ip_valid |=> !top_ff.net_g && !top_ff.net_r)
    else $error("network light lit without address");
  a_net_idle: assert property (run && ip_valid && !top_ff.tmo && !conn_open |=> top_ff.net_g == $past(blink_phase) && !top_ff.net_r)
    else $error("network idle blink wrong");
  a_net_conn: assert property (run && ip_valid && !top_ff.tmo && conn_open |=> top_ff.net_g && !top_ff.net_r)
    else $error("network not steady green");
  a_tmo_set: assert property (eo_timeout |=> top_ff.tmo)
    else $error("timeout not latched");
  a_tmo_hold: assert property (top_ff.tmo && !eo_all_up |=> top_ff.tmo)
    else $error("timeout dropped early");
endmodule

// >>> testbench/sli_observer.sv
`timescale 1ns/100ps
// ==========================================================
// watcher of the red power light, counts flashes per burst
module sli_observer #(
  parameter int TICK = 2
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic red,
  output int        bursts,
  output int        flashes,
  output int        pause,
  output int        on_len
);
  import sli_pkg::*;
  localparam int GAP = 2 * int'(BLINK_HALF_MS) * TICK; // dark that ends a burst
  int   dark;  // cycles dark so far
  int   cnt;   // flashes in burst under way
  int   on;    // cycles lit so far
  logic red_q; // light one sample back
  // ==========================================================
  // watch the light as a person would
  always @(posedge clock) begin
    red_q <= red;
    if (!reset_n) begin
      bursts <= 0;
      cnt    <= 0;
      dark   <= 0;
      on     <= 0;
    end else if (red) begin
      on   <= on + 1;
      dark <= 0;
      if (!red_q) begin
        cnt <= cnt + 1;
      end
      // long dark before a flash is the burst pause
      if (!red_q && dark > GAP) begin
        pause <= dark;
      end
    end else begin
      dark <= dark + 1;
      on   <= 0;
      if (red_q) begin
        on_len <= on;
      end
      // burst is over once dark outlasts a blink period
      if (dark == GAP && cnt != 0) begin
        bursts  <= bursts + 1;
        flashes <= cnt;
        cnt     <= 0;
      end
    end
  end
endmodule

// >>> testbench/tb_status_led_indicator.sv
`timescale 1ns/100ps
module tb_status_led_indicator;
  import sli_pkg::*;
  // ==========================================================
  // signals
  localparam int TICK = 2;                              // cycles per ms
  localparam int PER  = 2 * int'(BLINK_HALF_MS) * TICK; // one blink period
  localparam int STEP = int'(STARTUP_STEP_MS) * TICK;   // start-up step
  // rows: error, {wdog,cfg,ip,conn,tmo,allup}, classes mg mr ng nr, number
  localparam logic [19:0] ROWS [9] = '{
    {3'h0, 6'h1C, 8'h44, 3'h0}, {3'h0, 6'h0C, 8'h84, 3'h0},
    {3'h2, 6'h1C, 8'h24, 3'h2}, {3'h0, 6'h3C, 8'h14, 3'h6},
    {3'h0, 6'h14, 8'h40, 3'h0}, {3'h0, 6'h18, 8'h48, 3'h0},
    {3'h0, 6'h1E, 8'h42, 3'h0}, {3'h0, 6'h1C, 8'h42, 3'h0},
    {3'h0, 6'h1D, 8'h44, 3'h0}};
  logic        clock    = 1'b0;
  logic        reset_n  = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h0;
  logic [31:0] hwdata   = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  err_code = 3'h0;
  logic [5:0]  st       = 6'h0;  // wdog cfg ip conn tmo allup
  logic [5:0]  lt;               // net r g, mod r g, power r g
  logic [31:0] rd;               // last read data
  int          failures = 0;
  int          checked  = 0;
  int          cyc      = 0;
  int          hi [6];           // lit cycles per light
  int          bursts, flashes, pause, on_len;
  always #2.5 clock = ~clock;
  sli_status_led #(.TICK_CYC(TICK)) dut (.clock(clock), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .err_code(err_code), .wdog_fault(st[5]), .configured(st[4]), .ip_valid(st[3]),
    .conn_open(st[2]), .eo_timeout(st[1]), .eo_all_up(st[0]),
    .power_indicator_light_green(lt[0]), .power_indicator_light_red(lt[1]),
    .mod_green(lt[2]), .mod_red(lt[3]), .net_green(lt[4]), .net_red(lt[5]));
  sli_observer #(.TICK(TICK)) obs (.clock(clock), .reset_n(reset_n), .red(lt[1]),
    .bursts(bursts), .flashes(flashes), .pause(pause), .on_len(on_len));
  // ==========================================================
  // tasks
  task automatic test_done;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic near(input string what, input int exp, got, tol);
    checked++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // single word transfer, waits on hready
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    // idle cycle first, so a stored write has reached the error number
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic measure(input int n);
    hi = '{default: 0};
    repeat (n) begin
      @(posedge clock);
      for (int i = 0; i < 6; i++) begin
        hi[i] += int'(lt[i] === 1'b1);
      end
    end
  endtask
  // 0 dark, 1 steady, 2 even blink, 3 anything else
  function automatic logic [1:0] kind(input int c);
    return (c == 0) ? 2'h0 : (c == PER) ? 2'h1 : (c > PER/2-9 && c < PER/2+9) ? 2'h2 : 2'h3;
  endfunction
  task automatic classes(input logic [7:0] exp);
    measure(PER);
    check("mod green", exp[7:6], kind(hi[2]));
    check("mod red", exp[5:4], kind(hi[3]));
    check("net green", exp[3:2], kind(hi[4]));
    check("net red", exp[1:0], kind(hi[5]));
  endtask
  task automatic wait_burst;
    int b;
    b = bursts;
    while (bursts == b) @(posedge clock);
  endtask
  // ==========================================================
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      test_done();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    check("lights in reset", 32'h0, lt);
    check("ready in reset", 32'h1, hreadyout);
    st      <= 6'h18;
    reset_n <= 1'b1;
    repeat (STEP / 2) @(posedge clock);
    for (int s = 0; s < 4; s++) begin
      check("start step", 32'h1 << s, lt[5:2]);
      repeat (STEP) @(posedge clock);
    end
    classes(8'h88);
    $display("startup done");
    for (int r = 0; r < 9; r++) begin
      {err_code, st} <= ROWS[r][19:11];
      repeat (8) @(posedge clock);
      classes(ROWS[r][10:3]);
      bus(REG_STATUS, 1'b0, 32'h0);
      check("error number", ROWS[r][2:0], rd[2:0]);
    end
    $display("rows done");
    for (int n = 1; n < 8; n++) begin
      bus(REG_CTRL, 1'b1, 32'(n));
      bus(REG_STATUS, 1'b0, 32'h0);
      check("soft number", (n == 7) ? 32'h1 : 32'(n), rd[2:0]);
    end
    bus(REG_CTRL, 1'b1, 32'hFFFFFFF8);
    bus(REG_CTRL, 1'b0, 32'h0);
    check("ctrl", 32'h0, rd);
    bus(8'h10, 1'b1, 32'h5);
    bus(8'h10, 1'b0, 32'h0);
    check("unmapped", 32'h0, rd);
    $display("registers done");
    while (lt[0] !== 1'b1) @(posedge clock);
    measure(PER);
    near("green pulse", int'(PWR_PULSE_MS) * TICK, hi[0], 2);
    check("red when fine", 32'h0, hi[1]);
    err_code <= ERR_TEMPERATURE;
    wait_burst();
    check("flashes", 32'h3, 32'(flashes));
    near("flash length", int'(ERR_ON_MS) * TICK, on_len, 2);
    wait_burst();
    near("pause", (int'(ERR_PAUSE_MS) + int'(ERR_OFF_MS)) * TICK, pause, 4);
    st[5] <= 1'b1;
    wait_burst();
    check("watchdog flashes", 32'h6, 32'(flashes));
    $display("power done");
    test_done();
  end
endmodule
